// >>> ebh_pkg.sv
// constants and types shared by the external bus hold release block
package ebh_pkg;
  // ----------------------------------------------------------------
  // processor modes in which the hold feature is live
  // ----------------------------------------------------------------
  localparam logic [1:0] EBH_MODE_MEM_EXP = 2'h1;
  localparam logic [1:0] EBH_MODE_MICRO = 2'h3;

  // ----------------------------------------------------------------
  // bus widths
  // ----------------------------------------------------------------
  localparam int EBH_ADDR_W = 20;
  localparam int EBH_DATA_W = 16;
  localparam int EBH_CS_W = 4;

  // ----------------------------------------------------------------
  // reset levels
  // ----------------------------------------------------------------
  localparam logic EBH_REQ_IDLE_N = 1'b1; // request input inactive level
  localparam logic EBH_ACK_IDLE_N = 1'b1; // grant ack inactive level
  localparam logic EBH_BCLK_RST = 1'b0;

  // release sequence states
  typedef enum logic [1:0] {
    EBH_RUN,    // device owns the buses
    EBH_FLOAT,  // buses floated, ack waits for rising bus clock
    EBH_HOLD,   // ack low, other master owns the buses
    EBH_UNACK   // ack high again, buses restore at next rising edge
  } ebh_state_e;
endpackage

// >>> ebh_sync_if.sv
// carrier between the release logic and its request synchroniser
`timescale 1ns/1ps
`default_nettype none
interface ebh_sync_if;
  logic req_raw_n;  // hold request as it arrives at the pin
  logic req_sync_n; // same request after two flip-flops

  modport owner (output req_raw_n, input req_sync_n);
  modport sync (input req_raw_n, output req_sync_n);
endinterface
`default_nettype wire

// >>> ebh_req_sync.sv
// two-stage synchroniser for the active-low hold request
`timescale 1ns/1ps
`default_nettype none
module ebh_req_sync
  import ebh_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic srst_i,
  ebh_sync_if.sync sif
);
  typedef struct packed {
    logic meta;
    logic stable;
  } ebh_sync_s;

  ebh_sync_s s_r;
  ebh_sync_s s_nxt;

  // ----------------------------------------------------------------
  // next state: first stage feeds only the second
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.meta = sif.req_raw_n;
    s_nxt.stable = s_r.meta;
  end

  // idle level at reset so no stray request appears
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      s_r <= '{meta: EBH_REQ_IDLE_N, stable: EBH_REQ_IDLE_N};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sif.req_sync_n = s_r.stable;

  sync_depth_a: assert property (
    @(posedge clk_sys_i) disable iff (srst_i)
    ##2 (sif.req_sync_n == $past(sif.req_raw_n, 2)))
    else $error("hold request not delayed by two stages");
endmodule
`default_nettype wire

// >>> ebh_bus_release.sv
// external bus hold and release logic with registered pin drivers
`timescale 1ns/1ps
`default_nettype none
module ebh_bus_release
  import ebh_pkg::*;
#(
  parameter int ADDR_W = EBH_ADDR_W,
  parameter int DATA_W = EBH_DATA_W,
  parameter int CS_W = EBH_CS_W
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic [1:0] proc_mode_i,
  input wire logic hold_req_n_i,
  input wire logic bus_cycle_busy_i,
  input wire logic [ADDR_W-1:0] core_addr_i,
  input wire logic [DATA_W-1:0] core_data_i,
  input wire logic [DATA_W-1:0] core_data_oe_i,
  input wire logic core_rd_n_i,
  input wire logic core_wr_n_i,
  input wire logic core_wrl_n_i,
  input wire logic core_wrh_n_i,
  input wire logic core_ube_n_i,
  input wire logic [CS_W-1:0] core_cs_n_i,
  input wire logic core_ale_i,
  output logic bclk_o,
  output logic bus_grant_ack_n_o,
  output logic core_hold_o,
  output logic [ADDR_W-1:0] addr_o,
  output logic addr_oe_o,
  output logic [DATA_W-1:0] data_o,
  output logic [DATA_W-1:0] data_oe_o,
  output logic read_n_o,
  output logic write_n_o,
  output logic write_low_byte_n_o,
  output logic write_high_byte_n_o,
  output logic upper_byte_enable_n_o,
  output logic strobe_oe_o,
  output logic [CS_W-1:0] chip_select_lines_o,
  output logic chip_select_oe_o,
  output logic ale_o
);
  typedef struct packed {
    ebh_state_e st;
    logic bclk;
    logic ack_n;
    logic rel;
    logic [ADDR_W-1:0] addr;
    logic addr_oe;
    logic [DATA_W-1:0] data;
    logic [DATA_W-1:0] data_oe;
    logic rd_n;
    logic wr_n;
    logic wrl_n;
    logic wrh_n;
    logic ube_n;
    logic strobe_oe;
    logic [CS_W-1:0] cs_n;
    logic cs_oe;
    logic ale;
  } ebh_state_s;

  ebh_state_s s_r;
  ebh_state_s s_nxt;
  ebh_sync_if sif ();

  logic mode_ok;
  logic bclk_fall;
  logic bclk_rise;
  logic rel_nxt;

  // ----------------------------------------------------------------
  // request synchroniser
  // ----------------------------------------------------------------
  assign sif.req_raw_n = hold_req_n_i;

  ebh_req_sync u_sync (
    .clk_sys_i (clk_sys_i),
    .srst_i (srst_i),
    .sif (sif)
  );

  // bus clock edges as seen one system cycle ahead
  assign bclk_fall = s_r.bclk;
  assign bclk_rise = !s_r.bclk;
  assign mode_ok = (proc_mode_i == EBH_MODE_MEM_EXP) ||
                   (proc_mode_i == EBH_MODE_MICRO);

  // ----------------------------------------------------------------
  // release sequencer and pin drivers
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.bclk = !s_r.bclk;
    unique case (s_r.st)
      EBH_RUN: begin
        // a busy cycle always finishes first
        if (bclk_fall && !sif.req_sync_n && mode_ok &&
            !bus_cycle_busy_i) begin
          s_nxt.st = EBH_FLOAT;
        end
      end
      EBH_FLOAT: begin
        if (bclk_rise) begin
          s_nxt.st = EBH_HOLD;
          s_nxt.ack_n = 1'b0;
        end
      end
      EBH_HOLD: begin
        if (bclk_rise && sif.req_sync_n) begin
          s_nxt.st = EBH_UNACK;
          s_nxt.ack_n = EBH_ACK_IDLE_N;
        end
      end
      EBH_UNACK: begin
        if (bclk_rise) begin
          s_nxt.st = EBH_RUN;
        end
      end
    endcase
    rel_nxt = (s_nxt.st != EBH_RUN);
    s_nxt.rel = rel_nxt;
    // values keep following the core so restore shows the live state
    s_nxt.addr = core_addr_i;
    s_nxt.data = core_data_i;
    s_nxt.rd_n = core_rd_n_i;
    s_nxt.wr_n = core_wr_n_i;
    s_nxt.wrl_n = core_wrl_n_i;
    s_nxt.wrh_n = core_wrh_n_i;
    s_nxt.ube_n = core_ube_n_i;
    s_nxt.cs_n = core_cs_n_i;
    // enables ignore any port assignment of the pins
    s_nxt.addr_oe = !rel_nxt;
    s_nxt.data_oe = rel_nxt ? '0 : core_data_oe_i;
    s_nxt.strobe_oe = !rel_nxt;
    s_nxt.cs_oe = !rel_nxt;
    // latch enable never floats; it mirrors the bus clock in hold
    s_nxt.ale = rel_nxt ? s_nxt.bclk : core_ale_i;
  end

  // address, data, strobe and chip select pins float during reset, latch enable is held low; the core takes over one cycle after
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      s_r <= '0;
      s_r.st <= EBH_RUN;
      s_r.bclk <= EBH_BCLK_RST;
      s_r.ack_n <= EBH_ACK_IDLE_N;
      s_r.rd_n <= 1'b1;
      s_r.wr_n <= 1'b1;
      s_r.wrl_n <= 1'b1;
      s_r.wrh_n <= 1'b1;
      s_r.ube_n <= 1'b1;
      s_r.cs_n <= '1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs straight from the state register
  // ----------------------------------------------------------------
  assign bclk_o = s_r.bclk;
  assign bus_grant_ack_n_o = s_r.ack_n;
  assign core_hold_o = s_r.rel;
  assign addr_o = s_r.addr;
  assign addr_oe_o = s_r.addr_oe;
  assign data_o = s_r.data;
  assign data_oe_o = s_r.data_oe;
  assign read_n_o = s_r.rd_n;
  assign write_n_o = s_r.wr_n;
  assign write_low_byte_n_o = s_r.wrl_n;
  assign write_high_byte_n_o = s_r.wrh_n;
  assign upper_byte_enable_n_o = s_r.ube_n;
  assign strobe_oe_o = s_r.strobe_oe;
  assign chip_select_lines_o = s_r.cs_n;
  assign chip_select_oe_o = s_r.cs_oe;
  assign ale_o = s_r.ale;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  sequence float_seq;
    $fell(core_hold_o) ##0 1'b1;
  endsequence
  sequence grant_seq;
    s_r.st == EBH_FLOAT ##1 !bus_grant_ack_n_o;
  endsequence

  mode_gate_a: assert property (
    $rose(core_hold_o) |-> $past(mode_ok))
    else $error("bus released outside an expansion mode");
  float_on_fall_a: assert property (
    $rose(core_hold_o) |-> !bclk_o && !addr_oe_o)
    else $error("buses not floated on falling bus clock");
  ack_after_float_a: assert property (
    $rose(core_hold_o) |-> grant_seq)
    else $error("ack did not follow float at next rise");
  ack_release_a: assert property (
    !bus_grant_ack_n_o && sif.req_sync_n && !bclk_o
    |=> bus_grant_ack_n_o && bclk_o)
    else $error("ack not raised at next rising edge");
  restore_after_a: assert property (
    $rose(bus_grant_ack_n_o) |-> core_hold_o ##2 float_seq)
    else $error("buses not restored one bus clock after ack");
  float_in_hold_a: assert property (
    !bus_grant_ack_n_o |-> !addr_oe_o && data_oe_o == '0 &&
      !strobe_oe_o && !chip_select_oe_o)
    else $error("a bus driven while ack is low");
  no_mid_cycle_a: assert property (
    $rose(core_hold_o) |-> !$past(bus_cycle_busy_i))
    else $error("buses released during a bus cycle");
  ale_in_hold_a: assert property (
    core_hold_o |-> ale_o == bclk_o)
    else $error("latch enable not in phase with bus clock");
endmodule
`default_nettype wire

// >>> ebh_ext_master.sv
// external bus master model sharing the device buses
`timescale 1ns/1ps
`default_nettype none
module ebh_ext_master (
  input wire logic clk_sys_i,
  input wire logic start_i,
  input wire logic [7:0] hold_cycles_i,
  input wire logic bus_grant_ack_n_i,
  output logic hold_req_n_o,
  output logic bus_use_o
);
  int n;
  // one request per start pulse; gives up when never granted
  initial begin
    hold_req_n_o = 1'b1;
    bus_use_o = 1'b0;
    forever begin
      @(posedge clk_sys_i);
      if (start_i === 1'b1) begin
        #1 hold_req_n_o = 1'b0;
        n = 0;
        while (bus_grant_ack_n_i !== 1'b0 && n < 64) begin
          @(posedge clk_sys_i);
          n++;
        end
        // bus used only while granted, short or long tenure
        #1 bus_use_o = (n < 64);
        repeat (int'(hold_cycles_i) + 1) @(posedge clk_sys_i);
        #1 bus_use_o = 1'b0;
        hold_req_n_o = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb.sv
// self-checking bench for the external bus hold release block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ebh_pkg::*;
  logic clk_sys_i = 1'b0, srst_i = 1'b1, busy = 1'b0, start = 1'b0;
  logic c_ale = 1'b0, bclk, ack_n, hold, a_oe, s_oe, cs_oe, ale;
  logic req_n, bus_use, s1, s2, rq, hd, oe, pale;
  logic [1:0] mode = 2'h0;
  logic [7:0] len = 8'h0;
  logic [15:0] lf = 16'h6fbb;
  logic [EBH_ADDR_W-1:0] c_addr = '0, addr, pa;
  logic [EBH_DATA_W-1:0] c_data = '0, c_doe = '0, data, doe, pd, pdo;
  logic [4:0] c_str = 5'h1f, str, ps;
  logic [3:0] c_cs = 4'hf, cs, pc;
  int st = 0, mb = 0, n_mismatch = 0, num_checks = 0, n_grant = 0;

  always #50 clk_sys_i = ~clk_sys_i;
  always @(negedge ack_n) n_grant++;

  ebh_bus_release i_ebh_bus_release (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .proc_mode_i(mode),
    .hold_req_n_i(req_n), .bus_cycle_busy_i(busy),
    .core_addr_i(c_addr), .core_data_i(c_data), .core_data_oe_i(c_doe),
    .core_rd_n_i(c_str[4]), .core_wr_n_i(c_str[3]),
    .core_wrl_n_i(c_str[2]), .core_wrh_n_i(c_str[1]),
    .core_ube_n_i(c_str[0]), .core_cs_n_i(c_cs), .core_ale_i(c_ale),
    .bclk_o(bclk), .bus_grant_ack_n_o(ack_n), .core_hold_o(hold),
    .addr_o(addr), .addr_oe_o(a_oe), .data_o(data), .data_oe_o(doe),
    .read_n_o(str[4]), .write_n_o(str[3]), .write_low_byte_n_o(str[2]),
    .write_high_byte_n_o(str[1]), .upper_byte_enable_n_o(str[0]),
    .strobe_oe_o(s_oe), .chip_select_lines_o(cs),
    .chip_select_oe_o(cs_oe), .ale_o(ale));

  ebh_ext_master i_ebh_ext_master (
    .clk_sys_i(clk_sys_i), .start_i(start), .hold_cycles_i(len),
    .bus_grant_ack_n_i(ack_n), .hold_req_n_o(req_n),
    .bus_use_o(bus_use));

  task automatic chk(input logic [63:0] got, exp, input string m);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  task summarize;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // inputs move 1 ns after the edge; core values are random every cycle
  task tick;
    @(posedge clk_sys_i);
    #1;
    lf = nx(lf);
    c_addr = {lf[3:0], lf};
    lf = nx(lf);
    c_data = lf;
    lf = nx(lf);
    c_doe = lf;
    lf = nx(lf);
    {c_ale, c_cs, c_str} = lf[9:0];
  endtask

  // reference model: bus clock, two-flop request, release sequence
  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      st = 0;
      mb = 0;
      s1 = 1'b1;
      s2 = 1'b1;
      rq = 1'b1;
    end else begin
      case (st)
        0: if (mb == 1 && s2 == 1'b0 && !busy &&
          (mode == EBH_MODE_MEM_EXP || mode == EBH_MODE_MICRO)) st = 1;
        1: st = 2;
        2: if (mb == 0 && s2 == 1'b1) st = 3;
        default: if (mb == 0) st = 0;
      endcase
      s2 = s1;
      s1 = req_n;
      mb = 1 - mb;
      rq = 1'b0;
    end
    {pa, pd, pdo, ps, pc, pale} = {c_addr, c_data, c_doe, c_str, c_cs, c_ale};
    #2;
    hd = (st != 0);
    oe = !rq && !hd;
    chk({ack_n, hold, bclk}, {st != 2, hd, mb[0]}, "handshake");
    chk({a_oe, s_oe, cs_oe, doe}, {{3{oe}}, oe ? pdo : 16'h0}, "oe");
    chk(ale, rq ? 1'b0 : (hd ? mb[0] : pale), "ale");
    if (oe) chk({addr, data, str, cs}, {pa, pd, ps, pc}, "values");
    if (bus_use === 1'b1)
      chk({a_oe, s_oe, cs_oe, |doe, ack_n}, 0, "contention");
  end

  // one request from the far master, then wait for the buses to return
  task hold_seq(input logic [1:0] m, input int bc, input logic [7:0] l);
    int n, g;
    g = n_grant;
    mode = m;
    len = l;
    busy = (bc > 0);
    start = 1'b1;
    tick;
    start = 1'b0;
    repeat (bc + 1) tick;
    busy = 1'b0;
    n = 0;
    while (!(req_n === 1'b1 && ack_n === 1'b1 && hold === 1'b0) &&
      n < 300) begin
      tick;
      n++;
    end
    if (n >= 300) begin
      n_mismatch++;
      $display("mismatch at %0t: bus never returned", $time);
      summarize;
    end
    g = n_grant - g;
    chk(g, m == EBH_MODE_MEM_EXP || m == EBH_MODE_MICRO, "grants");
  endtask

  initial begin
    repeat (4) tick;
    srst_i = 1'b0;
    repeat (2) tick;
    for (int i = 0; i < 4; i++) hold_seq(2'(i), 0, 8'(i * 7));
    hold_seq(EBH_MODE_MICRO, 0, 8'h0);
    hold_seq(EBH_MODE_MEM_EXP, 9, 8'h2);
    summarize;
  end
endmodule
`default_nettype wire
